// ---- dv/amp_redundancy_monitor_properties.sv ----
`timescale 1ns/1ps
module amp_mon_checker #(
	parameter int unsigned FAST_CYC = 4
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Register bus
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_ack_o,
	input  wire logic [31:0] wb_dat_o,
	// Buttons
	input  wire logic        reset_btn_i,
	input  wire logic        force_backup_button_i,
	// Outputs
	input  wire logic        switch_backup_o,
	input  wire logic        backup_gain_full_o,
	input  wire logic        yellow_led_o,
	input  wire logic        red_led_o,
	input  wire logic        relay_energize_o
);
	localparam int FL = FAST_CYC + 1;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_rdata_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data changed without ack");
	a_reset_routing: assert property ($fell(rst_i) |-> !switch_backup_o && relay_energize_o)
		else $error("not on main amplifier after reset");
	a_gain_follows: assert property (backup_gain_full_o == switch_backup_o)
		else $error("backup gain does not follow routing");
	a_auto_alarm: assert property (
		$rose(switch_backup_o) && !force_backup_button_i |-> !relay_energize_o)
		else $error("automatic switch without relay release");
	a_main_fail_red: assert property (switch_backup_o && !relay_energize_o |-> red_led_o)
		else $error("red not steady after main failure");
	a_fail_hold: assert property ($rose(relay_energize_o) |-> reset_btn_i)
		else $error("failure cleared without reset button");
	a_force_fast: assert property (
		switch_backup_o && relay_energize_o |-> ##[1:FL] ($changed(yellow_led_o) || !switch_backup_o))
		else $error("yellow not fast flashing while forced");

	c_main_fail: cover property (switch_backup_o && !relay_energize_o);
	c_forced: cover property (switch_backup_o && relay_energize_o);
	c_alarm_cleared: cover property ($rose(relay_energize_o));
endmodule : amp_mon_checker

bind amp_redundancy_monitor amp_mon_checker #(.FAST_CYC(FAST_CYC)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .reset_btn_i(reset_btn_i),
	.force_backup_button_i(force_backup_button_i), .switch_backup_o(switch_backup_o),
	.backup_gain_full_o(backup_gain_full_o), .yellow_led_o(yellow_led_o),
	.red_led_o(red_led_o), .relay_energize_o(relay_energize_o)
);

// ---- dv/front_panel_model.sv ----
`timescale 1ns/1ps
module front_panel_model #(
	parameter int unsigned DET_W = 10,
	parameter int unsigned HOLD  = 12
) (
	// Clock
	input  wire logic             clk_i,
	// Detector codes and buttons
	output logic      [DET_W-1:0] main_level_o,
	output logic      [DET_W-1:0] backup_level_o,
	output logic                  reset_btn_o,
	output logic                  set_ref_btn_o,
	output logic                  force_btn_o
);
	initial begin
		main_level_o = '0;
		backup_level_o = '0;
		reset_btn_o = 1'b0;
		set_ref_btn_o = 1'b0;
		force_btn_o = 1'b0;
	end

	// Waits out synchroniser plus a sample tick before anyone looks
	task automatic levels(input logic [DET_W-1:0] m, input logic [DET_W-1:0] b);
		@(posedge clk_i);
		main_level_o <= m;
		backup_level_o <= b;
		repeat (16) @(posedge clk_i);
	endtask : levels

	task automatic press(input logic set);
		@(posedge clk_i);
		if (set) set_ref_btn_o <= 1'b1;
		else reset_btn_o <= 1'b1;
		repeat (HOLD) @(posedge clk_i);
		set_ref_btn_o <= 1'b0;
		reset_btn_o <= 1'b0;
		repeat (HOLD) @(posedge clk_i);
	endtask : press

	task automatic force_hold(input logic on);
		@(posedge clk_i);
		force_btn_o <= on;
		repeat (HOLD) @(posedge clk_i);
	endtask : force_hold
endmodule : front_panel_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic        clk_i, rst_i, cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [9:0]  ml, bl;
	logic        rb, sb, fb, sw, gain, yel, red, relay;
	int          mismatches, cmp_count;

	amp_redundancy_monitor #(.SLOW_CYC(8), .FAST_CYC(4), .RESTORE_CYC(200),
		.DEBOUNCE_CYC(4), .SAMPLE_CYC(4)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.main_level_i(ml), .backup_level_i(bl), .reset_btn_i(rb), .set_ref_btn_i(sb),
		.force_backup_button_i(fb), .switch_backup_o(sw), .backup_gain_full_o(gain),
		.yellow_led_o(yel), .red_led_o(red), .relay_energize_o(relay));

	front_panel_model #(.DET_W(10)) u_panel (.clk_i(clk_i), .main_level_o(ml),
		.backup_level_o(bl), .reset_btn_o(rb), .set_ref_btn_o(sb), .force_btn_o(fb));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk("ack_seen", 32'h1, {31'h0, ack});
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 4'hF, 32'h0);
		chk(n, e, q & m);
	endtask : rd

	task automatic pins(input logic [2:0] e);
		chk("sw_gain_relay", {29'h0, e}, {29'h0, sw, gain, relay});
	endtask : pins

	// Counts edges between two changes of the chosen lamp
	task automatic half(input string n, input logic r, input int e);
		int c;
		logic v;
		c = 0;
		for (int k = 0; k < 2; k++) begin
			v = r ? red : yel;
			c = 0;
			while ((r ? red : yel) === v && c < 40) begin
				@(posedge clk_i);
				c++;
			end
		end
		chk(n, e, c);
	endtask : half

	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		summarize();
	end

	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		pins(3'b001);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_UNSET);
		rd("margin", amp_mon_pkg::REG_CTRL, 32'hFF, 32'h20);
		wb(1'b1, amp_mon_pkg::REG_CTRL, 4'h0, 32'h55);
		rd("margin", amp_mon_pkg::REG_CTRL, 32'hFF, 32'h20);
		wb(1'b1, amp_mon_pkg::REG_CTRL, 4'h1, 32'h10);
		rd("margin", amp_mon_pkg::REG_CTRL, 32'hFF, 32'h10);
		rd("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
		half("yellow_slow", 1'b0, 8);
		u_panel.levels(10'h200, 10'h200);
		u_panel.press(1'b1);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_MONITOR);
		rd("ref_main", amp_mon_pkg::REG_REF_MAIN, 32'h3FF, 32'h200);
		rd("ref_backup", amp_mon_pkg::REG_REF_BACKUP, 32'h3FF, 32'h200);
		// One code short of the margin must not trip
		u_panel.levels(10'h1F1, 10'h1F1);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_MONITOR);
		pins(3'b001);
		chk("yellow_off", 32'h0, {31'h0, yel});
		u_panel.force_hold(1'b1);
		pins(3'b111);
		half("yellow_fast", 1'b0, 4);
		u_panel.force_hold(1'b0);
		pins(3'b001);
		u_panel.levels(10'h1F0, 10'h1F1);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_MAIN_FAIL);
		pins(3'b110);
		chk("red_steady", 32'h1, {31'h0, red});
		u_panel.levels(10'h1F0, 10'h100);
		u_panel.press(1'b1);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_MAIN_FAIL);
		pins(3'b110);
		u_panel.press(1'b0);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_UNSET);
		pins(3'b001);
		u_panel.levels(10'h200, 10'h200);
		u_panel.press(1'b1);
		u_panel.levels(10'h200, 10'h1F0);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_BACKUP_FAIL);
		pins(3'b000);
		half("red_slow", 1'b1, 8);
		u_panel.press(1'b0);
		u_panel.levels(10'h200, 10'h200);
		u_panel.press(1'b1);
		u_panel.levels(10'h1F0, 10'h1F0);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_LOW_INPUT);
		pins(3'b000);
		half("red_fast", 1'b1, 4);
		// Power returns: stored references come back only after the wait
		u_panel.levels(10'h200, 10'h200);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_WAIT);
		repeat (150) @(posedge clk_i);
		rd("state", amp_mon_pkg::REG_STATUS, 32'h7F, amp_mon_pkg::ST_WAIT);
		repeat (80) @(posedge clk_i);
		rd("restored", amp_mon_pkg::REG_STATUS, 32'h17F, 32'h108);
		rd("ref_main", amp_mon_pkg::REG_REF_MAIN, 32'h3FF, 32'h200);
		repeat (20) @(posedge clk_i);
		chk("yellow_steady", 32'h1, {31'h0, yel});
		summarize();
	end
endmodule : testbench

// ---- shared/amp_mon_pkg.sv ----
package amp_mon_pkg;

	// Clock and timing, each time in its own unit with the cycle count derived
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned SLOW_HALF_MS   = 500;
	localparam int unsigned SLOW_HALF_CYC  = CLK_HZ / 1000 * SLOW_HALF_MS;
	localparam int unsigned FAST_HALF_US   = 166_666;
	localparam int unsigned FAST_HALF_CYC  = CLK_HZ / 1_000_000 * FAST_HALF_US;
	localparam int unsigned RESTORE_S      = 180;
	localparam int unsigned RESTORE_CYC    = CLK_HZ * RESTORE_S;
	localparam int unsigned DEBOUNCE_MS    = 10;
	localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned SAMPLE_MS      = 10;
	localparam int unsigned SAMPLE_CYC     = CLK_HZ / 1000 * SAMPLE_MS;

	// Detector and margin widths
	localparam int unsigned DET_W          = 10;
	localparam int unsigned MARGIN_W       = 8;
	localparam logic [7:0]  MARGIN_RST     = 8'h20;

	// Register byte offsets
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_REF_MAIN   = 8'h08;
	localparam logic [7:0]  REG_REF_BACKUP = 8'h0C;
	localparam logic [7:0]  REG_LEVELS     = 8'h10;

	// Field positions
	localparam int unsigned STATUS_RESTORED_BIT = 8;
	localparam int unsigned STATUS_BACKUP_BIT   = 9;
	localparam int unsigned STATUS_RELAY_BIT    = 10;
	localparam int unsigned LEVELS_BACKUP_LSB   = 16;

	// Non-volatile record: marker above the two references
	localparam logic [3:0]  NV_MARKER      = 4'hA;
	localparam int unsigned NV_MARKER_W    = 4;

	typedef enum logic [6:0] {
		ST_BOOT        = 7'h01,
		ST_UNSET       = 7'h02,
		ST_WAIT        = 7'h04,
		ST_MONITOR     = 7'h08,
		ST_MAIN_FAIL   = 7'h10,
		ST_BACKUP_FAIL = 7'h20,
		ST_LOW_INPUT   = 7'h40
	} mon_state_t;

endpackage : amp_mon_pkg

// ---- src/amp_redundancy_monitor.sv ----
// Contract
// - Power-up or reset button: route via main amplifier, references unset.
// - Without references, flash yellow LED slowly.
// - Store-reference press captures both levels as references, starts monitoring.
// - Both levels within margin: change nothing.
// - Main down by margin, backup not: switch to backup, alarm, red steady.
// - After switching to backup, no more automatic switching until reset.
// - Both down by margin: low input, red fast flash, alarm.
// - On main, only backup down: alarm, red slow flash.
// - Backup gain reduced normally, full when switched to backup.
// - Failures hold until reset button; then store-reference resumes monitoring.
// - Captured references go to non-volatile memory.
// - After power return, wait three minutes for store press, else load references.
// - Monitoring on retrieved references keeps yellow LED steady.
// - Relay energized in normal operation, so power loss alarms.
// - Force-backup button held routes via backup; release restores routing.
// - Slow flash about once a second, fast about three times a second.
// - Forced switch active: yellow LED fast flash.
// - Any failure de-energizes the relay.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module amp_redundancy_monitor #(
	parameter int unsigned DET_W        = amp_mon_pkg::DET_W,
	parameter int unsigned MARGIN_W     = amp_mon_pkg::MARGIN_W,
	parameter int unsigned SLOW_CYC     = amp_mon_pkg::SLOW_HALF_CYC,
	parameter int unsigned FAST_CYC     = amp_mon_pkg::FAST_HALF_CYC,
	parameter int unsigned RESTORE_CYC  = amp_mon_pkg::RESTORE_CYC,
	parameter int unsigned DEBOUNCE_CYC = amp_mon_pkg::DEBOUNCE_CYC,
	parameter int unsigned SAMPLE_CYC   = amp_mon_pkg::SAMPLE_CYC
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic                  wb_ack_o,
	output logic      [31:0]      wb_dat_o,
	// Detector codes
	input  wire logic [DET_W-1:0] main_level_i,
	input  wire logic [DET_W-1:0] backup_level_i,
	// Push buttons, high while pressed
	input  wire logic             reset_btn_i,
	input  wire logic             set_ref_btn_i,
	input  wire logic             force_backup_button_i,
	// Switch, gain, indicators, relay
	output logic                  switch_backup_o,
	output logic                  backup_gain_full_o,
	output logic                  yellow_led_o,
	output logic                  red_led_o,
	output logic                  relay_energize_o
);

	localparam int unsigned NV_W = amp_mon_pkg::NV_MARKER_W + 2 * DET_W;

	typedef struct packed {
		amp_mon_pkg::mon_state_t st;
		logic                    restored;
		logic [DET_W-1:0]        ref_main;
		logic [DET_W-1:0]        ref_back;
		logic [DET_W-1:0]        main_s1;
		logic [DET_W-1:0]        main_s2;
		logic [DET_W-1:0]        back_s1;
		logic [DET_W-1:0]        back_s2;
		logic [MARGIN_W-1:0]     margin;
		logic [31:0]             slow_cnt;
		logic [31:0]             fast_cnt;
		logic [31:0]             samp_cnt;
		logic [31:0]             wait_cnt;
		logic                    slow_ph;
		logic                    fast_ph;
		logic                    samp_tick;
		logic                    nv_we;
		logic                    sw_backup;
		logic                    gain_full;
		logic                    yellow;
		logic                    red;
		logic                    relay;
		logic                    wb_ack;
		logic [31:0]             wb_dat;
	} mon_regs_t;

	mon_regs_t        r_ff;
	mon_regs_t        nxt_r;

	logic             rst_btn_press;
	logic             set_press;
	logic             force_level;
	logic [NV_W-1:0]  nv_rdata;
	logic             main_down;
	logic             back_down;
	logic             failed;
	logic             wb_req;

	button_debounce #(
		.CYC     (DEBOUNCE_CYC)
	) u_db_reset (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (reset_btn_i),
		.level_o (),
		.press_o (rst_btn_press)
	);

	button_debounce #(
		.CYC     (DEBOUNCE_CYC)
	) u_db_set (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (set_ref_btn_i),
		.level_o (),
		.press_o (set_press)
	);

	button_debounce #(
		.CYC     (DEBOUNCE_CYC)
	) u_db_force (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (force_backup_button_i),
		.level_o (force_level),
		.press_o ()
	);

	// reference record kept across power loss
	ref_nv_mem #(
		.W       (NV_W),
		.DEPTH   (2),
		.AW      (1)
	) u_nv (
		.clk_i   (clk_i),
		.we_i    (r_ff.nv_we),
		.addr_i  (1'b0),
		.wdata_i ({amp_mon_pkg::NV_MARKER, r_ff.ref_main, r_ff.ref_back}),
		.rdata_o (nv_rdata)
	);

	// down by at least the margin
	function automatic logic fell(input logic [DET_W-1:0]    lvl,
	                              input logic [DET_W-1:0]    rlvl,
	                              input logic [MARGIN_W-1:0] m);
		logic [DET_W+MARGIN_W:0] sum;
		sum = (DET_W + MARGIN_W + 1)'(lvl) + (DET_W + MARGIN_W + 1)'(m);
		return sum <= (DET_W + MARGIN_W + 1)'(rlvl);
	endfunction : fell

	// Free-running divider, one pulse per wrap
	function automatic logic [31:0] div_next(input logic [31:0] cnt,
	                                         input int unsigned  lim);
		return (cnt >= lim - 1) ? 32'h00000000 : cnt + 32'h00000001;
	endfunction : div_next

	assign main_down = fell(r_ff.main_s2, r_ff.ref_main, r_ff.margin);
	assign back_down = fell(r_ff.back_s2, r_ff.ref_back, r_ff.margin);
	assign wb_req    = wb_cyc_i & wb_stb_i;

	always_comb begin
		nxt_r           = r_ff;
		nxt_r.nv_we     = 1'b0;
		nxt_r.samp_tick = 1'b0;
		failed          = 1'b0;

		// Detector codes come from another domain; two flops first
		nxt_r.main_s1 = main_level_i;
		nxt_r.main_s2 = r_ff.main_s1;
		nxt_r.back_s1 = backup_level_i;
		nxt_r.back_s2 = r_ff.back_s1;

		nxt_r.slow_cnt = div_next(r_ff.slow_cnt, SLOW_CYC);
		if (r_ff.slow_cnt >= SLOW_CYC - 1) begin
			nxt_r.slow_ph = ~r_ff.slow_ph;
		end
		nxt_r.fast_cnt = div_next(r_ff.fast_cnt, FAST_CYC);
		if (r_ff.fast_cnt >= FAST_CYC - 1) begin
			nxt_r.fast_ph = ~r_ff.fast_ph;
		end
		nxt_r.samp_cnt  = div_next(r_ff.samp_cnt, SAMPLE_CYC);
		nxt_r.samp_tick = (r_ff.samp_cnt >= SAMPLE_CYC - 1);

		case (r_ff.st)
			amp_mon_pkg::ST_BOOT: begin
				// Record read is registered, valid by now
				if (nv_rdata[NV_W-1 -: amp_mon_pkg::NV_MARKER_W] == amp_mon_pkg::NV_MARKER) begin
					nxt_r.st       = amp_mon_pkg::ST_WAIT;
					nxt_r.wait_cnt = '0;
				end else begin
					nxt_r.st = amp_mon_pkg::ST_UNSET;
				end
			end
			amp_mon_pkg::ST_UNSET: begin
				nxt_r.st = amp_mon_pkg::ST_UNSET;
			end
			amp_mon_pkg::ST_WAIT: begin
				if (r_ff.wait_cnt >= RESTORE_CYC - 1) begin
					nxt_r.ref_main = nv_rdata[2*DET_W-1:DET_W];
					nxt_r.ref_back = nv_rdata[DET_W-1:0];
					nxt_r.restored = 1'b1;
					nxt_r.st       = amp_mon_pkg::ST_MONITOR;
				end else begin
					nxt_r.wait_cnt = r_ff.wait_cnt + 32'h00000001;
				end
			end
			amp_mon_pkg::ST_MONITOR: begin
				// Detectors cannot see the backup while it is routed, so no check then
				if (r_ff.samp_tick && !force_level) begin
					if (main_down && back_down) begin
						nxt_r.st = amp_mon_pkg::ST_LOW_INPUT;
					end else if (main_down) begin
						nxt_r.st = amp_mon_pkg::ST_MAIN_FAIL;
					end else if (back_down) begin
						nxt_r.st = amp_mon_pkg::ST_BACKUP_FAIL;
					end
				end
			end
			// failure states are left only by reset
			amp_mon_pkg::ST_MAIN_FAIL,
			amp_mon_pkg::ST_BACKUP_FAIL,
			amp_mon_pkg::ST_LOW_INPUT: begin
				nxt_r.st = r_ff.st;
			end
			default: begin
				nxt_r.st = amp_mon_pkg::ST_UNSET;
			end
		endcase

		if (set_press && (r_ff.st == amp_mon_pkg::ST_UNSET ||
		                  r_ff.st == amp_mon_pkg::ST_WAIT ||
		                  r_ff.st == amp_mon_pkg::ST_MONITOR)) begin
			nxt_r.ref_main = r_ff.main_s2;
			nxt_r.ref_back = r_ff.back_s2;
			nxt_r.restored = 1'b0;
			// record written the cycle after capture
			nxt_r.nv_we    = 1'b1;
			nxt_r.st       = amp_mon_pkg::ST_MONITOR;
		end

		// reset button restarts with references unset
		if (rst_btn_press) begin
			nxt_r.st       = amp_mon_pkg::ST_UNSET;
			nxt_r.restored = 1'b0;
			nxt_r.nv_we    = 1'b0;
		end

		// Wishbone: ack one cycle after request, dropped after one cycle
		nxt_r.wb_ack = wb_req & ~r_ff.wb_ack;
		if (wb_req && !r_ff.wb_ack) begin
			case (wb_adr_i)
				amp_mon_pkg::REG_CTRL: begin
					nxt_r.wb_dat = 32'(r_ff.margin);
				end
				amp_mon_pkg::REG_STATUS: begin
					nxt_r.wb_dat = 32'(r_ff.st);
					nxt_r.wb_dat[amp_mon_pkg::STATUS_RESTORED_BIT] = r_ff.restored;
					nxt_r.wb_dat[amp_mon_pkg::STATUS_BACKUP_BIT]   = r_ff.sw_backup;
					nxt_r.wb_dat[amp_mon_pkg::STATUS_RELAY_BIT]    = r_ff.relay;
				end
				amp_mon_pkg::REG_REF_MAIN: begin
					nxt_r.wb_dat = 32'(r_ff.ref_main);
				end
				amp_mon_pkg::REG_REF_BACKUP: begin
					nxt_r.wb_dat = 32'(r_ff.ref_back);
				end
				amp_mon_pkg::REG_LEVELS: begin
					nxt_r.wb_dat = 32'(r_ff.main_s2);
					nxt_r.wb_dat[amp_mon_pkg::LEVELS_BACKUP_LSB +: DET_W] = r_ff.back_s2;
				end
				default: begin
					nxt_r.wb_dat = 32'h00000000;
				end
			endcase
		end
		// margin write lands on the edge that sees ack
		if (wb_req && r_ff.wb_ack && wb_we_i && wb_sel_i[0] &&
		    wb_adr_i == amp_mon_pkg::REG_CTRL) begin
			nxt_r.margin = wb_dat_i[MARGIN_W-1:0];
		end

		// Outputs follow the next state so they settle with it
		failed = (nxt_r.st == amp_mon_pkg::ST_MAIN_FAIL) ||
		         (nxt_r.st == amp_mon_pkg::ST_BACKUP_FAIL) ||
		         (nxt_r.st == amp_mon_pkg::ST_LOW_INPUT);
		// auto switch or held force button routes backup
		nxt_r.sw_backup = (nxt_r.st == amp_mon_pkg::ST_MAIN_FAIL) | force_level;
		// full gain only when backup carries the signal
		nxt_r.gain_full = nxt_r.sw_backup;
		nxt_r.relay     = ~failed;

		case (nxt_r.st)
			amp_mon_pkg::ST_MAIN_FAIL:   nxt_r.red = 1'b1;
			amp_mon_pkg::ST_LOW_INPUT:   nxt_r.red = nxt_r.fast_ph;
			amp_mon_pkg::ST_BACKUP_FAIL: nxt_r.red = nxt_r.slow_ph;
			default:                     nxt_r.red = 1'b0;
		endcase

		if (force_level) begin
			nxt_r.yellow = nxt_r.fast_ph;
		end else if (nxt_r.st == amp_mon_pkg::ST_UNSET ||
		             nxt_r.st == amp_mon_pkg::ST_WAIT ||
		             nxt_r.st == amp_mon_pkg::ST_BOOT) begin
			nxt_r.yellow = nxt_r.slow_ph;
		end else begin
			nxt_r.yellow = nxt_r.restored;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_ff        <= '0;
			// start on main amplifier, references unset
			r_ff.st     <= amp_mon_pkg::ST_BOOT;
			r_ff.margin <= amp_mon_pkg::MARGIN_RST;
			r_ff.relay  <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign wb_ack_o           = r_ff.wb_ack;
	assign wb_dat_o           = r_ff.wb_dat;
	assign switch_backup_o    = r_ff.sw_backup;
	assign backup_gain_full_o = r_ff.gain_full;
	assign yellow_led_o       = r_ff.yellow;
	assign red_led_o          = r_ff.red;
	assign relay_energize_o   = r_ff.relay;

endmodule : amp_redundancy_monitor

// ---- src/button_debounce.sv ----
`timescale 1ns/1ps
module button_debounce #(
	parameter int unsigned CYC = amp_mon_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Raw button, high while pressed
	input  wire logic pin_i,
	// Debounced level and press pulse
	output logic      level_o,
	output logic      press_o
);

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        stable;
		logic [31:0] cnt;
		logic        press;
	} db_t;

	db_t r_ff;
	db_t nxt_r;

	always_comb begin
		nxt_r       = r_ff;
		nxt_r.s1    = pin_i;
		nxt_r.s2    = r_ff.s1;
		nxt_r.press = 1'b0;
		if (r_ff.s2 != r_ff.stable) begin
			// Level must hold for the full window before it counts
			if (r_ff.cnt >= CYC - 1) begin
				nxt_r.stable = r_ff.s2;
				nxt_r.cnt    = '0;
				nxt_r.press  = r_ff.s2;
			end else begin
				nxt_r.cnt = r_ff.cnt + 32'h00000001;
			end
		end else begin
			nxt_r.cnt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign level_o = r_ff.stable;
	assign press_o = r_ff.press;

endmodule : button_debounce

// ---- src/ref_nv_mem.sv ----
`timescale 1ns/1ps
module ref_nv_mem #(
	parameter int unsigned W     = 24,
	parameter int unsigned DEPTH = 2,
	parameter int unsigned AW    = 1
) (
	// Clock
	input  wire logic          clk_i,
	// Write and read port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [W-1:0]  wdata_i,
	output logic      [W-1:0]  rdata_o
);

	typedef struct packed {
		logic [W-1:0] rdata;
	} mem_rd_t;

	// Contents survive the system reset; only the fill models a blank part
	logic [W-1:0] mem [DEPTH];
	mem_rd_t      r_ff;
	mem_rd_t      nxt_r;

	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = '0;
		end
	end

	always_comb begin
		nxt_r       = r_ff;
		nxt_r.rdata = mem[addr_i];
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		r_ff <= nxt_r;
	end

	assign rdata_o = r_ff.rdata;

endmodule : ref_nv_mem
